// >>> dv/cwf_frame_tx_props.sv
// Port checker for the continuous weight frame transmitter
`timescale 1ns/1ps
module cwf_frame_tx_props
  import cwf_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        frame_active,
  input wire logic        frame_done,
  input wire logic        demand_print_inhibit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_inhibit_on_write: assert property (reg_wr && reg_addr == CWF_OFS_CTRL
    |=> demand_print_inhibit == $past(reg_wdata[CWF_CTRL_CONT])) else $error("inhibit wrong");
  a_inhibit_holds: assert property (!(reg_wr && reg_addr == CWF_OFS_CTRL)
    |=> $stable(demand_print_inhibit)) else $error("inhibit moved without write");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr != CWF_OFS_CTRL
    && reg_addr != CWF_OFS_STAT |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_upper_zero: assert property (reg_rd && reg_addr == CWF_OFS_CTRL
    |=> reg_rdata[31:6] == 26'h0) else $error("control upper bits set");
  a_status_busy: assert property (reg_rd && reg_addr == CWF_OFS_STAT
    |=> reg_rdata[0] == $past(frame_active)) else $error("busy bit wrong");
  a_done_in_frame: assert property (frame_done |-> $past(frame_active) ##1 !frame_done)
    else $error("done outside frame");
  a_start_on_enable: assert property (reg_wr && reg_addr == CWF_OFS_CTRL
    && reg_wdata[0] && !frame_active |-> ##[1:4] frame_active) else $error("no frame start");
  a_frame_restart: assert property (frame_done && $past(demand_print_inhibit)
    |=> frame_active [*3]) else $error("next frame not started");
endmodule // cwf_frame_tx_props

bind cwf_frame_tx cwf_frame_tx_props u_props (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_active(frame_active),
  .frame_done(frame_done), .demand_print_inhibit(demand_print_inhibit)
);

// >>> dv/cwf_serial_rx.sv
// Receiving host model: decodes serial characters from the transmitter
`timescale 1ns/1ps
module cwf_serial_rx (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        txd,
  input  wire logic [19:0] bit_div,
  output logic             rx_valid,
  output logic [6:0]       rx_data,
  output logic             rx_par,
  output logic             rx_err
);
  logic [9:0] sh;
  initial begin
    rx_valid = 1'h0;
    rx_data  = 7'h00;
    rx_par   = 1'h0;
    rx_err   = 1'h0;
    forever begin
      @(posedge core_clk);
      rx_valid <= 1'h0;
      if (!reset && txd === 1'h0) begin
        // Sample at bit centres so edge jitter of one clock is harmless
        repeat (bit_div / 2) @(posedge core_clk);
        sh[0] = txd;
        for (int i = 1; i < 10; i++) begin
          repeat (bit_div) @(posedge core_clk);
          sh[i] = txd;
        end
        rx_data  <= sh[7:1];
        rx_par   <= sh[8];
        rx_err   <= sh[0] | ~sh[9];
        rx_valid <= 1'h1;
      end
    end
  end
endmodule // cwf_serial_rx

// >>> dv/test_continuous_weight_frame_tx.sv
// Self-checking bench for the continuous weight frame transmitter
`timescale 1ns/1ps
module test_continuous_weight_frame_tx
  import cwf_pkg::*;
;
  logic core_clk, reset, reg_wr, reg_rd, txd, frame_active, frame_done, demand_print_inhibit;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, ctrl;
  logic [23:0] weight_bcd, tare_bcd;
  logic [2:0]  dp_code;
  logic [1:0]  incr_size_sel;
  logic setpoint1_active, setpoint2_active, net_mode, weight_negative, over_capacity;
  logic in_motion, unit_not_lb, within_zero_tol, power_up_flag, print_request;
  logic rx_valid, rx_par, rx_err;
  logic [6:0]  rx_data, ck;
  logic [19:0] rx_div;
  logic [16:0] lfsr_q;
  logic [6:0]  exp_q[$];
  int fail_count, checks, rx_cnt, cyc, fn, fstart, flen;

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  cwf_frame_tx #(.BIT_DIV_300(32)) dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .weight_bcd(weight_bcd),
    .tare_bcd(tare_bcd), .dp_code(dp_code), .incr_size_sel(incr_size_sel),
    .setpoint1_active(setpoint1_active), .setpoint2_active(setpoint2_active),
    .net_mode(net_mode), .weight_negative(weight_negative), .over_capacity(over_capacity),
    .in_motion(in_motion), .unit_not_lb(unit_not_lb), .within_zero_tol(within_zero_tol),
    .power_up_flag(power_up_flag), .print_request(print_request), .txd(txd),
    .frame_active(frame_active), .frame_done(frame_done),
    .demand_print_inhibit(demand_print_inhibit));

  cwf_serial_rx u_host (.core_clk(core_clk), .reset(reset), .txd(txd), .bit_div(rx_div),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_par(rx_par), .rx_err(rx_err));

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'h1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task automatic push(input logic [6:0] c);
    exp_q.push_back(c);
    ck = ck + c;
  endtask

  task automatic push_digits(input logic [23:0] bcd, input logic [2:0] dp);
    int keep;
    logic lead;
    logic [3:0] d;
    keep = (dp == CWF_DP_ONE) ? 1 : (dp == CWF_DP_TWO) ? 2 : (dp == CWF_DP_THREE) ? 3 : 0;
    lead = 1'h1;
    for (int i = 0; i < 6; i++) begin
      d = bcd[23-4*i -: 4];
      if (d != 4'h0 || i >= 5 - keep) lead = 1'h0;
      push(lead ? CWF_ASCII_SPACE : CWF_ASCII_ZERO + 7'(d));
    end
  endtask

  // New random scale data, then the frame it should produce
  task automatic new_frame(input logic dce, input logic spo);
    logic [23:0] w, t;
    logic [1:0] inc;
    for (int i = 0; i < 48; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (i < 24) w[i] = lfsr_q[0]; else t[i-24] = lfsr_q[0];
    end
    for (int i = 0; i < 6; i++) begin
      if (w[4*i+:4] > 4'h9) w[4*i+:4] = 4'h0;
      if (t[4*i+:4] > 4'h9) t[4*i+:4] = 4'h0;
    end
    @(posedge core_clk);
    weight_bcd <= w; tare_bcd <= t; dp_code <= 3'(1 + fn % 5); incr_size_sel <= 2'(fn);
    {setpoint1_active, setpoint2_active, net_mode, weight_negative} <= lfsr_q[3:0];
    {over_capacity, in_motion, unit_not_lb, within_zero_tol} <= lfsr_q[7:4];
    {power_up_flag, print_request} <= lfsr_q[9:8];
    fn++;
    #1 ck = 7'h00;
    inc = incr_size_sel == CWF_INC_X2 ? CWF_INCB_X2 :
          incr_size_sel == CWF_INC_X5 ? CWF_INCB_X5 : CWF_INCB_X1;
    if (dce) push(CWF_ASCII_STX);
    push({2'h3, spo ? {setpoint2_active, setpoint1_active} : inc, dp_code});
    push({spo ? within_zero_tol : power_up_flag, 1'h1, unit_not_lb, in_motion,
          over_capacity, weight_negative, net_mode});
    push({3'h7, print_request, 3'h0});
    push_digits(weight_bcd, dp_code);
    push_digits(tare_bcd, dp_code);
    push(CWF_ASCII_CR);
    if (dce) push(-ck);
  endtask

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (rx_cnt < n && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
  endtask

  always @(posedge core_clk) begin
    if (rx_valid) begin
      rx_cnt++;
      if (exp_q.size() == 0) check(32'(rx_data), 32'hFFFF);
      else check(32'(rx_data), 32'(exp_q.pop_front()));
      check(32'(rx_par), 32'(^rx_data));
      check(32'(rx_err), 32'h0);
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    reset = 1'h1; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 8'h00; reg_wdata = 32'h0;
    weight_bcd = 24'h0; tare_bcd = 24'h0; dp_code = 3'h2; incr_size_sel = 2'h0;
    {setpoint1_active, setpoint2_active, net_mode, weight_negative, over_capacity} = 5'h00;
    {in_motion, unit_not_lb, within_zero_tol, power_up_flag, print_request} = 5'h00;
    rx_div = 20'h20; lfsr_q = 17'h170B8; ck = 7'h00;
    repeat (5) @(posedge core_clk);
    reset <= 1'h0;
    rd(CWF_OFS_CTRL, v);
    check(v, 32'h0);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, v);
    check(v, 32'h0);
    rd(CWF_OFS_CTRL, v);
    check(v, 32'h0);
    for (int g = 0; g < 7; g++) begin
      // Rate moves only between frames: the host model cannot follow a mid-frame change
      // Code 6 lies above the fastest rate and must clamp to it
      rx_div = (g > 5) ? 20'h1 : 20'h20 >> g;
      flen = g[0] ? 16 : 18;
      fstart = rx_cnt;
      new_frame(~g[0], g[0] ^ g[1]);
      ctrl = {26'h0, 3'(g), g[0] ^ g[1], ~g[0], 1'h1};
      wr(CWF_OFS_CTRL, ctrl);
      rd(CWF_OFS_CTRL, v);
      check(v, ctrl);
      check(32'(demand_print_inhibit), 32'h1);
      for (int f = 0; f < 3; f++) begin
        wait_rx(fstart + 5);
        rd(CWF_OFS_STAT, v);
        check(32'(v[0]), 32'h1);
        if (f < 2) new_frame(~g[0], g[0] ^ g[1]);
        else wr(CWF_OFS_CTRL, ctrl & 32'hFFFF_FFFE);
        fstart += flen;
      end
      wait_rx(fstart);
      check(32'(exp_q.size()), 32'h0);
      for (int k = 0; k < 100 && frame_active !== 1'h0; k++) @(posedge core_clk);
      repeat (12 * rx_div) @(posedge core_clk);
      check(32'(rx_cnt), 32'(fstart));
      check(32'(demand_print_inhibit), 32'h0);
      rd(CWF_OFS_STAT, v);
      check(32'(v[31:16]), 32'(3 * (g + 1)));
      check(32'(v[0]), 32'h0);
      $display("test %0d done", g);
    end
    finish_test();
  end
endmodule // test_continuous_weight_frame_tx

// >>> rtl/cwf_char_if.sv
// Character handshake between the framer and the serializer
`timescale 1ns/1ps
interface cwf_char_if
  import cwf_pkg::*;
();
  logic                 valid;
  logic                 ready;
  logic [6:0]           data;
  logic [CWF_DIV_W-1:0] bit_div;

  modport framer     (output valid, output data, output bit_div, input ready);
  modport serializer (input valid, input data, input bit_div, output ready);
endinterface

// >>> rtl/cwf_digit_fmt.sv
// Six BCD digits to ASCII with leading blanking
`timescale 1ns/1ps
module cwf_digit_fmt
  import cwf_pkg::*;
(
  input  wire logic [4*CWF_NDIGIT-1:0] digits_bcd,
  input  wire logic [2:0]              dp_code,
  output logic      [7*CWF_NDIGIT-1:0] chars
);

  logic [2:0]          frac;
  logic [CWF_NDIGIT:0] lead;

  always_comb begin
    unique case (dp_code)
      CWF_DP_ONE:   frac = 3'h1;
      CWF_DP_TWO:   frac = 3'h2;
      CWF_DP_THREE: frac = 3'h3;
      default:      frac = 3'h0;
    endcase
  end

  assign lead[0] = 1'b1;

  // Char 0 is the most significant digit; the units digit is never blanked
  for (genvar g = 0; g < CWF_NDIGIT; g++) begin : g_dig
    logic [3:0] dig;
    logic       keep;
    assign dig        = digits_bcd[4*(CWF_NDIGIT-1-g) +: 4];
    assign lead[g+1]  = lead[g] & (dig == 4'h0);
    assign keep       = (g + 1 + int'(frac)) >= CWF_NDIGIT;
    assign chars[7*g +: 7] = (lead[g+1] && !keep) ? CWF_ASCII_SPACE
                                                  : (CWF_ASCII_ZERO | {3'h0, dig});
  end

endmodule // cwf_digit_fmt

// >>> rtl/cwf_frame_tx.sv
// Continuous weight frame transmitter: framing, status bytes and registers
// Operation
// - Continuous frames go out at a selectable rate from 300 to 9600 baud.
// - While continuous output runs, demand print formats are suppressed; the inhibit follows CWF_CTRL_CONT and drops before the last frame ends.
// - Each character: start, seven data, even parity, stop; receiver matches.
// - Frame has 18 characters with delimiter and check, 16 without.
// - Order: optional STX, status A, B, C, six weight, six tare digits.
// - Carriage return follows tare; check character follows when enabled.
// - Non-significant leading weight and tare digits are sent as spaces.
// - Status A bits 2..0 carry decimal point code; bits 5, 6 are one.
// - With setpoints on, status A bits 3, 4 report setpoint outputs.
// - With setpoints off, status A bits 3, 4 give increment size.
// - Status B: net, negative, overcapacity, motion in bits 0..3; bit 5 one.
// - Status B bit 4 is one for kilograms or any unit besides pounds.
// - Status B bit 6 is zero tolerance with setpoints, else power-up flag.
// - Status C bits 0..2 zero, bit 3 print request, bits 4..6 one.
// - Bit 7 of each status byte is that byte's parity.
// - Delimiter and check character are both sent only when enabled.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module cwf_frame_tx
  import cwf_pkg::*;
#(
  parameter int BIT_DIV_300 = CWF_BIT_DIV_300
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  input  wire logic [4*CWF_NDIGIT-1:0] weight_bcd,
  input  wire logic [4*CWF_NDIGIT-1:0] tare_bcd,
  input  wire logic [2:0]              dp_code,
  input  wire logic [1:0]              incr_size_sel,
  input  wire logic                    setpoint1_active,
  input  wire logic                    setpoint2_active,
  input  wire logic                    net_mode,
  input  wire logic                    weight_negative,
  input  wire logic                    over_capacity,
  input  wire logic                    in_motion,
  input  wire logic                    unit_not_lb,
  input  wire logic                    within_zero_tol,
  input  wire logic                    power_up_flag,
  input  wire logic                    print_request,
  output logic                         txd,
  output logic                         frame_active,
  output logic                         frame_done,
  output logic                         demand_print_inhibit
);

  localparam logic [CWF_DIV_W-1:0] DIV_BASE = CWF_DIV_W'(BIT_DIV_300);

  cwf_char_if chr ();

  cwf_state_t              state_q;
  logic [CWF_CTRL_W-1:0]   ctrl_q;
  logic [31:0]             rdata_q;
  logic [CWF_DIV_W-1:0]    bit_div_q;
  logic [6:0]              frame_q [CWF_NCHAR];
  logic [6:0]              frame_d [CWF_NCHAR];
  logic [4:0]              idx_q;
  logic [4:0]              last_q;
  logic                    valid_q;
  logic [6:0]              data_q;
  logic                    active_q;
  logic                    done_q;
  logic [CWF_FCNT_W-1:0]   fcnt_q;
  logic [7*CWF_NDIGIT-1:0] wchars;
  logic [7*CWF_NDIGIT-1:0] tchars;
  logic [6:0]              stat_a;
  logic [6:0]              stat_b;
  logic [6:0]              stat_c;
  logic [1:0]              incr_bits;
  logic [6:0]              ck_sum;
  logic [2:0]              baud_sel;
  logic                    cont_en;
  logic                    dce;
  logic                    spo;
  logic                    accept;
  logic                    last_char;

  assign cont_en  = ctrl_q[CWF_CTRL_CONT];
  assign dce      = ctrl_q[CWF_CTRL_DCE];
  assign spo      = ctrl_q[CWF_CTRL_SPO];
  assign baud_sel = ctrl_q[CWF_CTRL_BAUD_LSB +: 3];
  assign accept   = valid_q && chr.ready;
  // Serializer takes the final character of the frame in this cycle
  assign last_char = accept && (idx_q == last_q);

  assign chr.valid   = valid_q;
  assign chr.data    = data_q;
  assign chr.bit_div = bit_div_q;

  assign reg_rdata            = rdata_q;
  assign frame_active         = active_q;
  assign frame_done           = done_q;
  assign demand_print_inhibit = ctrl_q[CWF_CTRL_CONT];

  // ---------------------------------------------------------------- registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CWF_CTRL_RST;
    end else if (reg_wr && reg_addr == CWF_OFS_CTRL) begin
      ctrl_q <= reg_wdata[CWF_CTRL_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          CWF_OFS_CTRL: rdata_q[CWF_CTRL_W-1:0] <= ctrl_q;
          CWF_OFS_STAT: begin
            rdata_q[CWF_STAT_BUSY]            <= active_q;
            rdata_q[CWF_STAT_IDX_LSB +: 5]    <= idx_q;
            rdata_q[CWF_STAT_CNT_LSB +: CWF_FCNT_W] <= fcnt_q;
          end
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Rate codes above 9600 clamp to 9600; each step halves the bit time
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bit_div_q <= DIV_BASE;
    end else if (baud_sel > CWF_BAUD_MAX) begin
      bit_div_q <= DIV_BASE >> CWF_BAUD_MAX;
    end else begin
      bit_div_q <= DIV_BASE >> baud_sel;
    end
  end

  // ---------------------------------------------------------- frame contents
  cwf_digit_fmt u_wfmt (
    .digits_bcd (weight_bcd),
    .dp_code    (dp_code),
    .chars      (wchars)
  );

  cwf_digit_fmt u_tfmt (
    .digits_bcd (tare_bcd),
    .dp_code    (dp_code),
    .chars      (tchars)
  );

  always_comb begin
    unique case (incr_size_sel)
      CWF_INC_X2: incr_bits = CWF_INCB_X2;
      CWF_INC_X5: incr_bits = CWF_INCB_X5;
      default:    incr_bits = CWF_INCB_X1;
    endcase
  end

  always_comb begin
    stat_a[2:0] = dp_code;
    if (spo) begin
      stat_a[3] = setpoint1_active;
      stat_a[4] = setpoint2_active;
    end else begin
      stat_a[4:3] = incr_bits;
    end
    stat_a[6:5] = 2'h3;
  end

  always_comb begin
    stat_b[0] = net_mode;
    stat_b[1] = weight_negative;
    stat_b[2] = over_capacity;
    stat_b[3] = in_motion;
    stat_b[4] = unit_not_lb;
    stat_b[5] = 1'b1;
    stat_b[6] = spo ? within_zero_tol : power_up_flag;
  end

  assign stat_c = {3'h7, print_request, 3'h0};

  // Status bytes carry 7 data bits; the serializer appends even parity as bit 7
  always_comb begin
    ck_sum = 7'h00;
    frame_d[CWF_POS_STX] = CWF_ASCII_STX;
    frame_d[CWF_POS_A]     = stat_a;
    frame_d[CWF_POS_A + 1] = stat_b;
    frame_d[CWF_POS_A + 2] = stat_c;
    for (int i = 0; i < CWF_NDIGIT; i++) begin
      frame_d[CWF_POS_W0 + i] = wchars[7*i +: 7];
      frame_d[CWF_POS_T0 + i] = tchars[7*i +: 7];
    end
    frame_d[CWF_POS_CR] = CWF_ASCII_CR;
    for (int i = 0; i <= int'(CWF_POS_CR); i++) begin
      ck_sum = ck_sum + frame_d[i];
    end
    frame_d[CWF_POS_CK] = 7'(~ck_sum + 7'h01);
  end

  // --------------------------------------------------------------- sequencer
  // Enables are sampled once per frame so a frame is never half one layout
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= CWF_ST_IDLE;
    end else begin
      unique case (state_q)
        CWF_ST_IDLE: begin
          if (cont_en) begin
            state_q <= CWF_ST_SNAP;
          end
        end
        CWF_ST_SNAP: begin
          state_q <= CWF_ST_SEND;
        end
        CWF_ST_SEND: begin
          if (last_char) begin
            // Switching off lets the running frame finish cleanly
            state_q <= cont_en ? CWF_ST_SNAP : CWF_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Index rests on the last position between frames; status shows where it ended
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      idx_q  <= 5'h00;
      last_q <= CWF_POS_CR;
    end else if (state_q == CWF_ST_SNAP) begin
      idx_q  <= dce ? CWF_POS_STX : CWF_POS_A;
      last_q <= dce ? CWF_POS_CK : CWF_POS_CR;
    end else if (state_q == CWF_ST_SEND && accept && !last_char) begin
      idx_q <= idx_q + 5'h01;
    end
  end

  // Whole frame is captured in one cycle so the check character matches the bytes
  // that are sent, even while the scale data keep moving
  for (genvar p = 0; p < CWF_NCHAR; p++) begin : g_slot
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        frame_q[p] <= 7'h00;
      end else if (state_q == CWF_ST_SNAP) begin
        frame_q[p] <= frame_d[p];
      end
    end
  end

  // One idle cycle between characters keeps the handshake a plain flop
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
      data_q  <= 7'h00;
    end else if (accept) begin
      valid_q <= 1'b0;
    end else if (state_q == CWF_ST_SEND && !valid_q) begin
      valid_q <= 1'b1;
      data_q  <= frame_q[idx_q];
    end
  end

  // Busy follows the sequencer a cycle late so the pin leaves a flop
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active_q <= 1'b0;
    end else begin
      active_q <= (state_q != CWF_ST_IDLE);
    end
  end

  // One-cycle pulse in the cycle after the last character of a frame is taken
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last_char;
    end
  end

  // Frame count wraps silently; software takes differences, not absolutes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fcnt_q <= '0;
    end else if (last_char) begin
      fcnt_q <= fcnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------- serializer
  cwf_uart_tx u_uart (
    .core_clk (core_clk),
    .reset    (reset),
    .chr      (chr.serializer),
    .txd      (txd)
  );

endmodule // cwf_frame_tx

// >>> rtl/cwf_pkg.sv
// Shared constants and types for the continuous weight frame transmitter
package cwf_pkg;

  // Register map (byte addresses on the plain register port)
  localparam logic [7:0]  CWF_OFS_CTRL      = 8'h00;
  localparam logic [7:0]  CWF_OFS_STAT      = 8'h04;

  // Control register fields
  localparam int          CWF_CTRL_CONT     = 0;
  localparam int          CWF_CTRL_DCE      = 1;
  localparam int          CWF_CTRL_SPO      = 2;
  localparam int          CWF_CTRL_BAUD_LSB = 3;
  localparam int          CWF_CTRL_W        = 6;
  localparam logic [5:0]  CWF_CTRL_RST      = 6'h00;

  // Status register fields
  localparam int          CWF_STAT_BUSY     = 0;
  localparam int          CWF_STAT_IDX_LSB  = 1;
  localparam int          CWF_STAT_CNT_LSB  = 16;
  localparam int          CWF_FCNT_W        = 16;

  // Rate select: 0=300, 1=600, 2=1200, 3=2400, 4=4800, 5=9600 baud
  localparam logic [2:0]  CWF_BAUD_MAX      = 3'h5;
  localparam int          CWF_CLK_HZ        = 125_000_000;
  localparam int          CWF_BASE_BAUD     = 300;
  localparam int          CWF_BIT_DIV_300   = CWF_CLK_HZ / CWF_BASE_BAUD;
  localparam int          CWF_DIV_W         = 20;

  // Character codes
  localparam logic [6:0]  CWF_ASCII_STX     = 7'h02;
  localparam logic [6:0]  CWF_ASCII_CR      = 7'h0D;
  localparam logic [6:0]  CWF_ASCII_SPACE   = 7'h20;
  localparam logic [6:0]  CWF_ASCII_ZERO    = 7'h30;

  // Frame layout; positions are zero based, STX at 0
  localparam int          CWF_NDIGIT        = 6;
  localparam int          CWF_NCHAR         = 18;
  localparam logic [4:0]  CWF_POS_STX       = 5'h00;
  localparam logic [4:0]  CWF_POS_A         = 5'h01;
  localparam logic [4:0]  CWF_POS_CR        = 5'h10;
  localparam logic [4:0]  CWF_POS_CK        = 5'h11;
  localparam int          CWF_POS_W0        = 4;
  localparam int          CWF_POS_T0        = 10;

  // Decimal point codes
  localparam logic [2:0]  CWF_DP_TENS       = 3'h1;
  localparam logic [2:0]  CWF_DP_NONE       = 3'h2;
  localparam logic [2:0]  CWF_DP_ONE        = 3'h3;
  localparam logic [2:0]  CWF_DP_TWO        = 3'h4;
  localparam logic [2:0]  CWF_DP_THREE      = 3'h5;

  // Increment size select and the status A bits {bit4, bit3} sent for it
  localparam logic [1:0]  CWF_INC_X1        = 2'h0;
  localparam logic [1:0]  CWF_INC_X2        = 2'h1;
  localparam logic [1:0]  CWF_INC_X5        = 2'h2;
  localparam logic [1:0]  CWF_INCB_X1       = 2'h0;
  localparam logic [1:0]  CWF_INCB_X2       = 2'h1;
  localparam logic [1:0]  CWF_INCB_X5       = 2'h3;

  // Serial character: start, 7 data, parity, stop
  localparam int          CWF_UART_BITS     = 10;
  localparam logic [3:0]  CWF_UART_LAST     = 4'h9;

  typedef enum logic [2:0] {
    CWF_ST_IDLE = 3'b001,
    CWF_ST_SNAP = 3'b010,
    CWF_ST_SEND = 3'b100
  } cwf_state_t;

endpackage

// >>> rtl/cwf_uart_tx.sv
// Asynchronous character serializer, 7 data bits with even parity
`timescale 1ns/1ps
module cwf_uart_tx
  import cwf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  cwf_char_if.serializer  chr,
  output logic            txd
);

  logic [CWF_UART_BITS-1:0] shift_q;
  logic [3:0]               bit_cnt_q;
  logic [CWF_DIV_W-1:0]     div_cnt_q;
  logic [CWF_DIV_W-1:0]     div_q;
  logic                     busy_q;
  logic                     txd_q;

  assign chr.ready = !busy_q;
  assign txd       = txd_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shift_q   <= '1;
      bit_cnt_q <= 4'h0;
      div_cnt_q <= '0;
      div_q     <= '0;
      busy_q    <= 1'b0;
      txd_q     <= 1'b1;
    end else if (!busy_q) begin
      if (chr.valid) begin
        // Divisor latched per character so a rate change never splits one
        shift_q   <= {1'b1, ^chr.data, chr.data, 1'b0};
        div_q     <= chr.bit_div;
        bit_cnt_q <= 4'h0;
        div_cnt_q <= '0;
        busy_q    <= 1'b1;
        txd_q     <= 1'b0;
      end
    end else if (div_cnt_q == div_q - 1'b1) begin
      div_cnt_q <= '0;
      if (bit_cnt_q == CWF_UART_LAST) begin
        busy_q <= 1'b0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= {1'b1, shift_q[CWF_UART_BITS-1:1]};
        txd_q     <= shift_q[1];
      end
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

endmodule // cwf_uart_tx
